// *** hw/sapp_defines.vh ***
// constants for the converter control and parallel host port
`ifndef SAPP_DEFINES_VH
`define SAPP_DEFINES_VH
`define SAPP_RES_W          12
`define SAPP_BUS_W          12
`define SAPP_CLK_PS         5000
// wake-up from light power-down, in ns
`define SAPP_LIGHT_WAKE_NS  620
`define SAPP_LIGHT_WAKE_CYC \
    ((`SAPP_LIGHT_WAKE_NS * 1000 + `SAPP_CLK_PS - 1) / `SAPP_CLK_PS)
// start to first bit decision window, in ns
`define SAPP_FIRST_DEC_NS   400
`define SAPP_FIRST_DEC_CYC  ((`SAPP_FIRST_DEC_NS * 1000) / `SAPP_CLK_PS)
// cycles per bit decision
`define SAPP_BIT_CYC        8
// reference settle time after deep power-down, in ns (4.2 ms)
`define SAPP_REF_SETTLE_NS  4200000
// split so the product stays inside 32-bit integer range
`define SAPP_REF_SETTLE_CYC \
    ((`SAPP_REF_SETTLE_NS / 1000) * (1000000 / `SAPP_CLK_PS))
`define SAPP_CNT_W          20
// signed bipolar msb flip
`define SAPP_MSB_FLIP       12'h800
`define SAPP_RESULT_RST     12'h000
`endif

// *** hw/sapp_sar_step.v ***
// one successive-approximation bit decision stage
`timescale 1ns/1ps
module sapp_sar_step (
    input  wire [11:0] trial_i,
    input  wire [11:0] sample_i,
    input  wire [3:0]  bit_i,
    output wire [11:0] next_o
);
    wire [11:0] mask;
    wire [11:0] cand;
    assign mask   = 12'h001 << bit_i;
    assign cand   = trial_i | mask;
    // keep the bit when the candidate does not exceed the held sample
    assign next_o = (cand <= sample_i) ? cand : trial_i;
endmodule // sapp_sar_step

// *** hw/sapp_port.v ***
// converter control and parallel host port
//
// Contract
// RULE_01 - start on trigger fall with select low
// RULE_02 - strobes ignored while select is high
// RULE_03 - drive data only when read and select low
// RULE_04 - busy low throughout a running conversion
// RULE_05 - result valid before busy rises (the latch loads on the same edge that busy rises)
// RULE_06 - host releases trigger early or after busy
// RULE_07 - deep power-down clears reference settled flag
// RULE_08 - settled flag rises after reference settles
// RULE_09 - light power-down; host waits 620ns wake
// RULE_10 - upper select puts four msbs low
// RULE_11 - byte layout low byte, high byte zero-padded
// RULE_12 - word variant gives full 12-bit result
// RULE_13 - byte variant straight or offset binary
// RULE_14 - word bipolar uses two's complement
// RULE_15 - byte bipolar uses offset binary
// RULE_16 - running conversion cannot be restarted
// RULE_17 - finished result loads output latches
// RULE_18 - twelve timed bit decisions per conversion
// RULE_19 - starts rejected in power-down or unsettled
`timescale 1ns/1ps
`include "sapp_defines.vh"
module sapp_port #(
    parameter REF_SETTLE_CYC = `SAPP_REF_SETTLE_CYC,
    parameter BYTE_WIDE      = 0
) (
    input  wire        clk_i,
    input  wire        reset_i,
    input  wire        clk_en_i,
    input  wire        chip_select_n_i,
    input  wire        conversion_trigger_n_i,
    input  wire        read_n_i,
    input  wire        upper_byte_select_i,
    input  wire        deep_power_down_n_i,
    input  wire        light_power_down_n_i,
    input  wire        bipolar_i,
    input  wire [11:0] sample_i,
    output reg  [11:0] data_o,
    output reg  [11:0] data_oe_n_o,
    output reg         busy_n_o,
    output reg         reference_settled_o,
    output reg         light_awake_o
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SETL = 3'b010;
    localparam [2:0] ST_CONV = 3'b100;
    // counts worked out as integers, then cut to the timer width
    localparam integer FIRST_INT = `SAPP_FIRST_DEC_CYC;
    localparam integer BIT_INT   = `SAPP_BIT_CYC;
    localparam integer WAKE_INT  = `SAPP_LIGHT_WAKE_CYC;
    localparam integer SETL_INT  = REF_SETTLE_CYC;
    localparam [19:0]  FIRST_CYC = FIRST_INT[19:0];
    localparam [19:0]  BIT_CYC   = BIT_INT[19:0];
    localparam [19:0]  WAKE_CYC  = WAKE_INT[19:0];
    localparam [19:0]  SETL_CYC  = SETL_INT[19:0];

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg         trig_q;
    reg  [19:0] tmr_q;
    reg  [19:0] tmr_d;
    reg  [3:0]  bit_q;
    reg  [3:0]  bit_d;
    reg  [11:0] trial_q;
    reg  [11:0] trial_d;
    reg  [11:0] held_q;
    reg  [11:0] held_d;
    reg  [11:0] latch_q;
    reg  [11:0] latch_d;
    reg         settled_d;
    reg  [19:0] wake_q;
    wire [11:0] step_val;
    wire        trig_fall;
    wire        start_ok;
    wire        read_act;
    reg  [11:0] coded;
    reg  [11:0] bus_val;

    ////////////////////////////////////////////////////////////////////
    // start detection
    assign trig_fall = trig_q & ~conversion_trigger_n_i;
    // select gates the edge; busy, power-down and settled gate it too
    assign start_ok  = trig_fall & ~chip_select_n_i          // RULE_01 RULE_02
                     & (state_q == ST_IDLE)                  // RULE_16
                     & deep_power_down_n_i & reference_settled_o // RULE_19
                     & light_power_down_n_i;                 // RULE_09

    sapp_sar_step u_step (
        .trial_i  (trial_q),
        .sample_i (held_q),
        .bit_i    (bit_q),
        .next_o   (step_val)
    );

    ////////////////////////////////////////////////////////////////////
    // sequencer
    always @* begin
        state_d   = state_q;
        tmr_d     = tmr_q;
        bit_d     = bit_q;
        trial_d   = trial_q;
        held_d    = held_q;
        latch_d   = latch_q;
        settled_d = reference_settled_o;
        case (state_q)
            ST_SETL: begin
                if (tmr_q >= SETL_CYC) begin
                    settled_d = 1'b1;                        // RULE_08
                    state_d   = ST_IDLE;
                end else begin
                    tmr_d = tmr_q + 20'h00001;
                end
            end
            ST_CONV: begin
                if (tmr_q != 20'h00000) begin
                    tmr_d = tmr_q - 20'h00001;
                end else begin
                    trial_d = step_val;                      // RULE_18
                    tmr_d   = BIT_CYC - 20'h00001;
                    bit_d   = bit_q - 4'h1;
                    if (bit_q == 4'h0) begin
                        latch_d = step_val;                  // RULE_17 RULE_05
                        state_d = ST_IDLE;
                    end
                end
            end
            default: begin
                if (start_ok) begin
                    state_d = ST_CONV;
                    held_d  = sample_i;
                    trial_d = `SAPP_RESULT_RST;
                    bit_d   = 4'hb;
                    tmr_d   = FIRST_CYC - 20'h00001;
                end
            end
        endcase
        if (!deep_power_down_n_i) begin
            state_d   = ST_SETL;                             // RULE_07
            settled_d = 1'b0;
            tmr_d     = 20'h00000;
        end
    end

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q             <= ST_SETL;
            trig_q              <= 1'b1;
            tmr_q               <= 20'h00000;
            bit_q               <= 4'h0;
            trial_q             <= `SAPP_RESULT_RST;
            held_q              <= `SAPP_RESULT_RST;
            latch_q             <= `SAPP_RESULT_RST;
            reference_settled_o <= 1'b0;
            busy_n_o            <= 1'b1;
            wake_q              <= 20'h00000;
            light_awake_o       <= 1'b0;
        end else if (clk_en_i) begin
            state_q             <= state_d;
            trig_q              <= conversion_trigger_n_i;
            tmr_q               <= tmr_d;
            bit_q               <= bit_d;
            trial_q             <= trial_d;
            held_q              <= held_d;
            latch_q             <= latch_d;
            reference_settled_o <= settled_d;
            busy_n_o            <= ~(state_d == ST_CONV);    // RULE_04
            // light power-down keeps the reference alive, only the wake counts
            if (!light_power_down_n_i) begin
                wake_q        <= 20'h00000;
                light_awake_o <= 1'b0;
            end else if (wake_q < WAKE_CYC) begin
                wake_q        <= wake_q + 20'h00001;
            end else begin
                light_awake_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output coding and bus drive
    always @* begin
        coded = latch_q;
        if (bipolar_i && !BYTE_WIDE) begin
            coded = latch_q ^ `SAPP_MSB_FLIP;                // RULE_14
        end
        // byte variant keeps offset binary, unipolar stays straight
        bus_val = coded;                                     // RULE_12 RULE_13 RULE_15
        if (BYTE_WIDE) begin
            if (upper_byte_select_i) begin
                bus_val = {8'h00, coded[11:8]};              // RULE_10 RULE_11
            end else begin
                bus_val = {4'h0, coded[7:0]};                // RULE_11
            end
        end
    end

    assign read_act = ~read_n_i & ~chip_select_n_i;          // RULE_03 RULE_02

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            data_o      <= 12'h000;
            data_oe_n_o <= 12'hfff;
        end else if (clk_en_i) begin
            data_o      <= bus_val;
            // upper lines of the byte variant are unused pins, kept off
            data_oe_n_o <= read_act ? (BYTE_WIDE ? 12'hf00 : 12'h000)
                                    : 12'hfff;               // RULE_03
        end
    end
endmodule // sapp_port

// *** sim/sapp_port_asserts.sv ***
// checker on the converter host port pins
`timescale 1ns/1ps
module sapp_port_chk #(
    parameter REF_SETTLE_CYC = 20,
    parameter BYTE_WIDE      = 0
) (
    input wire        clk_i,
    input wire        reset_i,
    input wire        clk_en_i,
    input wire        chip_select_n_i,
    input wire        conversion_trigger_n_i,
    input wire        read_n_i,
    input wire        deep_power_down_n_i,
    input wire        light_power_down_n_i,
    input wire [11:0] data_oe_n_o,
    input wire        busy_n_o,
    input wire        reference_settled_o,
    input wire        light_awake_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire trg = conversion_trigger_n_i;
    wire rdy = reference_settled_o && light_power_down_n_i;
    wire go  = clk_en_i && !chip_select_n_i && deep_power_down_n_i;
    wire rd  = clk_en_i && !chip_select_n_i && !read_n_i;
    wire nrd = clk_en_i && (chip_select_n_i || read_n_i);
    property p_start; $fell(trg) && go && rdy && busy_n_o |=> !busy_n_o;
    endproperty
    property p_cs; $fell(trg) && chip_select_n_i && busy_n_o |=> busy_n_o;
    endproperty
    // byte variant never drives the four top lines
    property p_drv;
        rd |=> data_oe_n_o == (BYTE_WIDE ? 12'hf00 : 12'h000);
    endproperty
    property p_hiz; nrd |=> data_oe_n_o == 12'hfff; endproperty
    // 80 cycles to the first decision, eleven more at 8 cycles each
    property p_len; $fell(busy_n_o) |-> ##167 !busy_n_o ##1 busy_n_o;
    endproperty
    property p_pd; !deep_power_down_n_i |=> !reference_settled_o;
    endproperty
    property p_wake; $rose(deep_power_down_n_i) |-> !reference_settled_o[*8];
    endproperty
    property p_rej; $fell(trg) && busy_n_o && !rdy |=> busy_n_o; endproperty
    property p_nap; !light_power_down_n_i |=> !light_awake_o; endproperty
    a_start: assert property (p_start) else $error("start lost");
    a_cs: assert property (p_cs) else $error("start taken");
    a_drv: assert property (p_drv) else $error("not driven");
    a_hiz: assert property (p_hiz) else $error("driven");
    a_len: assert property (p_len) else $error("busy length");
    a_pd: assert property (p_pd) else $error("settled high");
    a_wake: assert property (p_wake) else $error("settled early");
    a_rej: assert property (p_rej) else $error("start taken");
    a_nap: assert property (p_nap) else $error("awake");
    c_conv: cover property ($rose(busy_n_o));
    c_read: cover property (rd);
    c_wake: cover property ($rose(reference_settled_o));
    c_again: cover property ($fell(trg) && go && !busy_n_o);
endmodule // sapp_port_chk
bind sapp_port sapp_port_chk #(
    .REF_SETTLE_CYC(REF_SETTLE_CYC),
    .BYTE_WIDE(BYTE_WIDE)
) u_chk (.*);

// *** sim/sapp_host.sv ***
// host model: one start, then a word read and a two-byte read
`timescale 1ns/1ps
module sapp_host (
    input  wire        clk_i,
    input  wire        busy_n_i,
    input  wire [11:0] data_i,
    input  wire [11:0] oe_n_i,
    input  wire [11:0] bdata_i,
    input  wire [11:0] boe_n_i,
    output reg         cs_n_o,
    output reg         trig_n_o,
    output reg         rd_n_o,
    output reg         hi_o
);
    initial {cs_n_o, trig_n_o, rd_n_o, hi_o} = 4'b1110;
    // undriven lines read inverted, so a float never passes
    task automatic convert(input bit sel, input bit again, output bit ok,
                           output logic [11:0] d, lb, hb, output int n);
        bit lo;
        lo = 0;
        ok = 0;
        n  = 0;
        d  = 12'h000;
        lb = 12'h000;
        hb = 12'h000;
        cs_n_o <= !sel;
        @(posedge clk_i) trig_n_o <= 1'b0;
        for (int i = 0; i < 250 && !ok; i++) begin
            @(posedge clk_i);
            ok = lo & busy_n_i;
            lo = lo | !busy_n_i;
            if (!busy_n_i) n++;
            // release early; a second fall while busy is ignored
            if (i == 4) trig_n_o <= 1'b1;
            if (i == 8 && again) trig_n_o <= 1'b0;
        end
        if (ok) begin
            rd_n_o <= 1'b0;
            repeat (2) @(posedge clk_i);
            d  = ~(data_i ^ ~oe_n_i);
            lb = ~(bdata_i ^ ~boe_n_i);
            // byte select only moves while the read strobe is up
            rd_n_o <= 1'b1;
            hi_o   <= 1'b1;
            @(posedge clk_i) rd_n_o <= 1'b0;
            repeat (2) @(posedge clk_i);
            hb = ~(bdata_i ^ ~boe_n_i);
            rd_n_o <= 1'b1;
            @(posedge clk_i) hi_o <= 1'b0;
        end
        rd_n_o   <= 1'b1;
        cs_n_o   <= 1'b1;
        trig_n_o <= 1'b1;
    endtask
endmodule // sapp_host

// *** sim/tb_top.sv ***
// self-checking bench for the converter host port
`timescale 1ns/1ps
`include "sapp_defines.vh"
module tb_top;
    logic clk_i = 0, reset_i = 1, deep_n = 1, light_n = 1, bip = 0;
    logic [11:0] smp = 0, data, oe_n, bdata, boe_n, d, r, lb, hb, exp_q[$];
    logic busy_n, settled, awake, cs_n, trig_n, rd_n, hi;
    bit ok, b;
    int err_count = 0, n_compared = 0;
    // first decision 400 ns after the start, the other eleven 8 cycles apart
    localparam int CONV_CYC = `SAPP_FIRST_DEC_CYC + 11 * `SAPP_BIT_CYC;
    always #2.5 clk_i = ~clk_i;
    sapp_port #(.REF_SETTLE_CYC(20)) u_dut (.clk_i(clk_i),
        .reset_i(reset_i), .clk_en_i(1'b1), .chip_select_n_i(cs_n),
        .conversion_trigger_n_i(trig_n), .read_n_i(rd_n),
        .upper_byte_select_i(hi), .deep_power_down_n_i(deep_n),
        .light_power_down_n_i(light_n), .bipolar_i(bip), .sample_i(smp),
        .data_o(data), .data_oe_n_o(oe_n), .busy_n_o(busy_n),
        .reference_settled_o(settled), .light_awake_o(awake));
    // byte-wide twin on the same strobes, read in two halves
    sapp_port #(.REF_SETTLE_CYC(20), .BYTE_WIDE(1)) u_dut_byte (
        .clk_i(clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
        .chip_select_n_i(cs_n), .conversion_trigger_n_i(trig_n),
        .read_n_i(rd_n), .upper_byte_select_i(hi),
        .deep_power_down_n_i(deep_n), .light_power_down_n_i(light_n),
        .bipolar_i(bip), .sample_i(smp), .data_o(bdata),
        .data_oe_n_o(boe_n), .busy_n_o(), .reference_settled_o(),
        .light_awake_o());
    sapp_host u_host (.clk_i(clk_i), .busy_n_i(busy_n), .data_i(data),
        .oe_n_i(oe_n), .bdata_i(bdata), .boe_n_i(boe_n), .cs_n_o(cs_n),
        .trig_n_o(trig_n), .rd_n_o(rd_n), .hi_o(hi));
    task check(input logic [11:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        if (err_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // word bipolar is two's complement: msb flipped; bytes stay offset
    task run(input bit sel, input bit want, input bit again = 1'b0);
        logic [11:0] e;
        int n;
        e = smp;
        if (want) exp_q.push_back(bip ? e ^ 12'h800 : e);
        u_host.convert(sel, again, ok, d, lb, hb, n);
        check(12'(ok), 12'(want));
        check(12'(n), want ? 12'(CONV_CYC) : 12'h000);
        if (want) begin
            check(d, exp_q.pop_front());
            check({4'h0, lb[7:0]}, {4'h0, e[7:0]});
            check({4'h0, hb[7:0]}, {8'h00, e[11:8]});
        end
        if (want && !ok) finish_test;
    endtask
    task settle;
        for (int i = 0; i < 40 && settled !== 1'b1; i++) @(posedge clk_i);
        check(12'(settled), 12'h001);
        if (settled !== 1'b1) finish_test;
    endtask
    initial begin
        void'($urandom(32'h1c28));
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        settle;
        for (int k = 0; k < 6; k++) begin
            {b, r} = 13'($urandom);
            if (k < 2) r = 12'h7ff + 12'(k);
            smp <= r;
            bip <= b;
            @(posedge clk_i) run(1, 1, k == 3);
            repeat (2) @(posedge clk_i);
            check(oe_n, 12'hfff);
            check(boe_n, 12'hfff);
        end
        run(0, 0);
        @(posedge clk_i) light_n <= 1'b0;
        run(1, 0);
        check(12'(awake), 12'h000);
        light_n <= 1'b1;
        repeat (124) @(posedge clk_i);
        check(12'(awake), 12'h000);
        repeat (2) @(posedge clk_i);
        check(12'(awake), 12'h001);
        run(1, 1);
        @(posedge clk_i) deep_n <= 1'b0;
        repeat (2) @(posedge clk_i);
        check(12'(settled), 12'h000);
        deep_n <= 1'b1;
        run(1, 0);
        settle;
        run(1, 1);
        finish_test;
    end
endmodule // tb_top
